// ===== core/irq_route_pkg.sv
/*
  Constants for the interrupt request routing block.
  Assumes a single 125 MHz core clock and synchronous active-high reset.
*/
package irq_route_pkg;
  localparam int NUM_LINES = 10;
  localparam int SRC_W = 3;
  // Line positions in the request vector: 3,4,5,6,7,9,10,11,12,15
  localparam int LINE_THREE = 0;
  localparam int LINE_FOUR = 1;
  localparam int LINE_FIVE = 2;
  localparam int LINE_SIX = 3;
  localparam int LINE_SEVEN = 4;
  localparam int LINE_TWELVE = 8;
  // Source codes for a plug-and-play line
  typedef enum logic [SRC_W-1:0] {
    SRC_NONE,
    SRC_SERIAL_ONE,
    SRC_SERIAL_TWO,
    SRC_PARALLEL,
    SRC_FLOPPY,
    SRC_SIRQ_ONE,
    SRC_SIRQ_TWO,
    SRC_SIRQ_THREE
  } src_sel_e;
  localparam logic [1:0] SER_ALL_OFF = 2'h0;
  localparam int SER_IDX_ONE = 0;
  localparam int SER_IDX_TWO = 1;
endpackage

// ===== core/set_ready_change.sv
/*
  Per-channel change detector for the data-set-ready input of a serial channel.
  Assumes the input is synchronous to the core clock; read_ack clears the flag.
*/
`timescale 1ns/10ps
module set_ready_change (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic set_ready_n,
  input wire logic read_ack,
  output logic change_flag
);
  logic last_r;
  logic last_nxt;
  logic flag_r;
  logic flag_nxt;

  always_comb begin
    last_nxt = set_ready_n;
    // A change in the clearing cycle still sets the flag
    flag_nxt = (flag_r & ~read_ack) | (set_ready_n ^ last_r);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      last_r <= 1'b1;
      flag_r <= 1'b0;
    end else if (ce) begin
      last_r <= last_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign change_flag = flag_r;
endmodule

// ===== core/multi_io_irq_routing.sv
/*
  Interrupt request routing for a multi-function I/O controller.
  Assumes synchronous inputs, and that the host clears causes via its service routine.
*/
// Operation
// RULE1 - Plug-and-play pins push-pull or open-drain
// RULE2 - Plug-and-play pin driven by selected source
// RULE3 - Line twelve shares pin; five shares rate
// RULE4 - Legacy three/four carry COM port interrupts
// RULE5 - Serial requests high, low after service
// RULE6 - Lines five, seven follow acknowledge when enabled
// RULE7 - Five/seven bidirectional only in extended mode
// RULE8 - Line six high on floppy completion
// RULE9 - Line six high when non-DMA byte ready
// RULE10 - Set-ready change raises modem status request
// RULE11 - Unassigned plug-and-play pin left undriven
`timescale 1ns/10ps
module multi_io_irq_routing
  import irq_route_pkg::*;
#(
  parameter int LINES = irq_route_pkg::NUM_LINES
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic PNP_MODE_IN,
  input wire logic [LINES*irq_route_pkg::SRC_W-1:0] LINE_SRC_SEL_IN,
  input wire logic [LINES-1:0] LINE_OPEN_DRAIN_IN,
  input wire logic [LINES-1:0] LINE_PIN_IN,
  input wire logic [1:0] SERIAL_IRQ_IN,
  input wire logic [1:0] SERIAL_IS_COM24_IN,
  input wire logic [1:0] SERIAL_SVC_DONE_IN,
  input wire logic [1:0] MODEM_IRQ_EN_IN,
  input wire logic [1:0] SET_READY_N_IN,
  input wire logic [1:0] MODEM_STATUS_READ_IN,
  input wire logic PAR_IRQ_EN_IN,
  input wire logic PAR_ACK_N_IN,
  input wire logic EXT_PAR_MODE_IN,
  input wire logic LINE_FIVE_CFG_IN,
  input wire logic LINE_SEVEN_CFG_IN,
  input wire logic FLOPPY_DONE_IN,
  input wire logic FLOPPY_BYTE_READY_IN,
  input wire logic FLOPPY_NON_DMA_IN,
  input wire logic FLOPPY_SVC_DONE_IN,
  input wire logic SERIAL_IRQ_INPUT_ONE_IN,
  input wire logic SERIAL_IRQ_INPUT_TWO_IN,
  input wire logic SERIAL_IRQ_INPUT_THREE_IN,
  input wire logic ALT_RATE_SEL_IN,
  input wire logic ALT_RATE_VAL_IN,
  input wire logic SHARED_TWELVE_AS_LINE_IN,
  output logic [LINES-1:0] LINE_OUT,
  output logic [LINES-1:0] LINE_OE_OUT,
  output logic SET_READY_IN_TWO_OUT,
  output logic INFRARED_RECEIVE_TWO_OUT,
  output logic [1:0] SET_READY_CHANGE_FLAG_OUT,
  output logic [1:0] SERIAL_REQ_OUT
);
  import irq_route_pkg::*;

  logic [1:0] ser_req_r;
  logic [1:0] ser_req_nxt;
  logic floppy_req_r;
  logic floppy_req_nxt;
  logic [LINES-1:0] line_r;
  logic [LINES-1:0] line_nxt;
  logic [LINES-1:0] oe_r;
  logic [LINES-1:0] oe_nxt;
  logic [1:0] dsr_flag;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dsr
      set_ready_change u_chg (
        .clk(CORE_CLK_IN),
        .rst(RST_IN),
        .ce(CLK_EN_IN),
        .set_ready_n(SET_READY_N_IN[g]),
        .read_ack(MODEM_STATUS_READ_IN[g]),
        .change_flag(dsr_flag[g])
      );
    end
  endgenerate

  function automatic logic src_level(input logic [SRC_W-1:0] sel, input logic [1:0] ser,
                                     input logic par, input logic fdc, input logic [2:0] sirq);
    unique case (src_sel_e'(sel))
      SRC_NONE: src_level = 1'b0;
      SRC_SERIAL_ONE: src_level = ser[SER_IDX_ONE];
      SRC_SERIAL_TWO: src_level = ser[SER_IDX_TWO];
      SRC_PARALLEL: src_level = par;
      SRC_FLOPPY: src_level = fdc;
      SRC_SIRQ_ONE: src_level = sirq[0];
      SRC_SIRQ_TWO: src_level = sirq[1];
      SRC_SIRQ_THREE: src_level = sirq[2];
    endcase
  endfunction

  // Serial and floppy request latches
  always_comb begin
    ser_req_nxt = ser_req_r;
    for (int i = 0; i < 2; i++) begin
      // Set wins over service clear so a late event is not lost
      if (SERIAL_SVC_DONE_IN[i]) begin
        ser_req_nxt[i] = 1'b0; // RULE5
      end
      if (SERIAL_IRQ_IN[i] | (dsr_flag[i] & MODEM_IRQ_EN_IN[i])) begin
        ser_req_nxt[i] = 1'b1; // RULE10
      end
    end
    floppy_req_nxt = floppy_req_r;
    if (FLOPPY_SVC_DONE_IN) begin
      floppy_req_nxt = 1'b0;
    end
    if (FLOPPY_DONE_IN | (FLOPPY_NON_DMA_IN & FLOPPY_BYTE_READY_IN)) begin
      floppy_req_nxt = 1'b1; // RULE8 RULE9
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ser_req_r <= SER_ALL_OFF;
      floppy_req_r <= 1'b0;
    end else if (CLK_EN_IN) begin
      ser_req_r <= ser_req_nxt;
      floppy_req_r <= floppy_req_nxt;
    end
  end

  // Pin drive
  always_comb begin
    logic [2:0] sirq;
    logic [SRC_W-1:0] sel;
    logic [1:0] ser_en;
    sirq = {SERIAL_IRQ_INPUT_THREE_IN, SERIAL_IRQ_INPUT_TWO_IN, SERIAL_IRQ_INPUT_ONE_IN};
    sel = '0;
    ser_en = 2'h0;
    line_nxt = '0;
    oe_nxt = '0;
    if (PNP_MODE_IN) begin
      for (int i = 0; i < LINES; i++) begin
        sel = LINE_SRC_SEL_IN[i*SRC_W +: SRC_W];
        if (sel != SRC_NONE) begin
          line_nxt[i] = src_level(sel, ser_req_r, ~PAR_ACK_N_IN, floppy_req_r, sirq); // RULE2
          // Open drain only pulls low; a high request releases the line
          oe_nxt[i] = LINE_OPEN_DRAIN_IN[i] ? ~line_nxt[i] : 1'b1; // RULE1
          if (LINE_OPEN_DRAIN_IN[i]) begin
            line_nxt[i] = 1'b0;
          end
        end // RULE11
      end
      if (ALT_RATE_SEL_IN) begin
        line_nxt[LINE_FIVE] = ALT_RATE_VAL_IN; // RULE3
        oe_nxt[LINE_FIVE] = 1'b1;
      end
      if (!SHARED_TWELVE_AS_LINE_IN) begin
        line_nxt[LINE_TWELVE] = 1'b0; // RULE3
        oe_nxt[LINE_TWELVE] = 1'b0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        ser_en[i] = ser_req_r[i];
      end
      line_nxt[LINE_THREE] = |(ser_en & SERIAL_IS_COM24_IN); // RULE4 RULE5
      line_nxt[LINE_FOUR] = |(ser_en & ~SERIAL_IS_COM24_IN); // RULE4
      oe_nxt[LINE_THREE] = 1'b1;
      oe_nxt[LINE_FOUR] = 1'b1;
      line_nxt[LINE_SIX] = floppy_req_r; // RULE8 RULE9
      oe_nxt[LINE_SIX] = 1'b1;
      if (PAR_IRQ_EN_IN) begin
        // Acknowledge is low-true; the line is high-true
        line_nxt[LINE_FIVE] = ~PAR_ACK_N_IN; // RULE6
        line_nxt[LINE_SEVEN] = ~PAR_ACK_N_IN; // RULE6
        // In extended mode a configured line is released as an input
        oe_nxt[LINE_FIVE] = ~(EXT_PAR_MODE_IN & LINE_FIVE_CFG_IN); // RULE7
        oe_nxt[LINE_SEVEN] = ~(EXT_PAR_MODE_IN & LINE_SEVEN_CFG_IN); // RULE7
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      line_r <= '0;
      oe_r <= '0;
    end else if (CLK_EN_IN) begin
      line_r <= line_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign LINE_OUT = line_r;
  assign LINE_OE_OUT = oe_r;
  // Shared pin input functions seen when line twelve is not driving
  assign SET_READY_IN_TWO_OUT = LINE_PIN_IN[LINE_TWELVE];
  assign INFRARED_RECEIVE_TWO_OUT = LINE_PIN_IN[LINE_TWELVE];
  assign SET_READY_CHANGE_FLAG_OUT = dsr_flag;
  assign SERIAL_REQ_OUT = ser_req_r;

  AST_LEGACY_FLOPPY: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE8
    CLK_EN_IN && !PNP_MODE_IN && floppy_req_r |=> LINE_OUT[LINE_SIX] && LINE_OE_OUT[LINE_SIX])
    else $error("Line six not high after floppy request");
  AST_BYTE_READY: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE9
    CLK_EN_IN && FLOPPY_NON_DMA_IN && FLOPPY_BYTE_READY_IN |=> floppy_req_r)
    else $error("Byte ready did not raise floppy request");
  AST_PAR_OFF: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE6
    CLK_EN_IN && !PNP_MODE_IN && !PAR_IRQ_EN_IN |=> !LINE_OE_OUT[LINE_FIVE] && !LINE_OE_OUT[LINE_SEVEN])
    else $error("Parallel lines driven while disabled");
  AST_PAR_FOLLOW: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE6
    CLK_EN_IN && !PNP_MODE_IN && PAR_IRQ_EN_IN |=> LINE_OUT[LINE_SEVEN] == !$past(PAR_ACK_N_IN))
    else $error("Line seven does not follow acknowledge");
  AST_PAR_BIDIR: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE7
    CLK_EN_IN && !PNP_MODE_IN && PAR_IRQ_EN_IN && !EXT_PAR_MODE_IN |=> LINE_OE_OUT[LINE_FIVE])
    else $error("Line five released outside extended mode");
  AST_COM24: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE4
    CLK_EN_IN && !PNP_MODE_IN && ser_req_r[0] && SERIAL_IS_COM24_IN[0] |=> LINE_OUT[LINE_THREE])
    else $error("Line three missing serial request");
  AST_SVC_CLEAR: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE5
    CLK_EN_IN && SERIAL_SVC_DONE_IN[0] && !SERIAL_IRQ_IN[0] && !dsr_flag[0] |=> !ser_req_r[0])
    else $error("Serial request not cleared after service");
  AST_MODEM: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE10
    CLK_EN_IN && dsr_flag[1] && MODEM_IRQ_EN_IN[1] |=> ser_req_r[1])
    else $error("Set-ready change did not raise request");
  AST_UNASSIGNED: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE11
    CLK_EN_IN && PNP_MODE_IN && LINE_SRC_SEL_IN[SRC_W*LINE_SEVEN +: SRC_W] == SRC_NONE
    |=> !LINE_OE_OUT[LINE_SEVEN])
    else $error("Unassigned line driven");
  AST_OPEN_DRAIN: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // RULE1
    LINE_OE_OUT[LINE_FOUR] && PNP_MODE_IN && $past(PNP_MODE_IN) && $past(CLK_EN_IN)
    && $past(LINE_OPEN_DRAIN_IN[LINE_FOUR]) |-> !LINE_OUT[LINE_FOUR])
    else $error("Open drain line driven high");
endmodule

// ===== tb/host_irq_model.sv
/*
  Host interrupt controller model: resolves the shared request lines and
  runs the service routine. Assumes pulled-up lines and the core clock.
*/
`timescale 1ns/10ps
module host_irq_model (
  input wire logic clk,
  input wire logic svc_en,
  input wire logic [3:0] svc_delay,
  input wire logic [irq_route_pkg::NUM_LINES-1:0] line_out,
  input wire logic [irq_route_pkg::NUM_LINES-1:0] line_oe,
  output logic [irq_route_pkg::NUM_LINES-1:0] line_pin,
  output logic [1:0] serial_done,
  output logic floppy_done
);
  import irq_route_pkg::*;
  int cnt = 0;
  logic [NUM_LINES-1:0] drv;
  // A released line floats up, never keeping its last driven value
  assign line_pin = (line_out & line_oe) | ~line_oe;
  assign drv = line_out & line_oe;
  // Service runs after a chosen delay; the device must then drop the line
  always @(posedge clk) begin
    serial_done <= 2'h0;
    floppy_done <= 1'b0;
    cnt <= 0;
    if (svc_en && (drv[LINE_THREE] || drv[LINE_FOUR] || drv[LINE_SIX])) begin
      cnt <= cnt + 1;
      if (cnt >= svc_delay) begin
        serial_done <= 2'h3;
        floppy_done <= 1'b1;
      end
    end
  end
endmodule

// ===== tb/tb_top.sv
/*
  Self-checking bench for the request routing block.
  Assumes the host model on the far side and inputs driven on falling edges.
*/
`timescale 1ns/10ps
module tb_top;
  import irq_route_pkg::*;
  logic clk = 0, rst = 1, pnp = 0, svc_en = 0, par_en = 0, ack_n = 1;
  logic fd_done = 0, fd_byte = 0, fd_ndma = 0, s1 = 0, s2 = 0, s3 = 0;
  logic ar_sel = 0, ar_val = 0, tw_line = 1;
  logic ext = 0, cfg5 = 0, cfg7 = 0, ce = 1;
  logic [3:0] svc_dly = 0;
  logic [29:0] sel = 0;
  logic [9:0] od = 0, lout, loe, lpin;
  logic [1:0] sirq = 0, com24 = 0, mien = 0, srn = 2'h3, msr = 0, sdone, flag, req;
  logic fdone, sr2, ir;
  logic [51:0] exp_q[$];
  logic [25:0] mon, m, e;
  int err_count = 0, checked = 0;
  event obs_ev;
  always #4 clk = ~clk;
  assign mon = {ir, req, flag, sr2, loe, lout};
  multi_io_irq_routing u_multi_io_irq_routing (.CORE_CLK_IN(clk), .RST_IN(rst),
    .CLK_EN_IN(ce), .PNP_MODE_IN(pnp), .LINE_SRC_SEL_IN(sel), .LINE_OPEN_DRAIN_IN(od),
    .LINE_PIN_IN(lpin), .SERIAL_IRQ_IN(sirq), .SERIAL_IS_COM24_IN(com24),
    .SERIAL_SVC_DONE_IN(sdone), .MODEM_IRQ_EN_IN(mien), .SET_READY_N_IN(srn),
    .MODEM_STATUS_READ_IN(msr), .PAR_IRQ_EN_IN(par_en), .PAR_ACK_N_IN(ack_n),
    .EXT_PAR_MODE_IN(ext), .LINE_FIVE_CFG_IN(cfg5), .LINE_SEVEN_CFG_IN(cfg7),
    .FLOPPY_DONE_IN(fd_done), .FLOPPY_BYTE_READY_IN(fd_byte), .FLOPPY_NON_DMA_IN(fd_ndma),
    .FLOPPY_SVC_DONE_IN(fdone), .SERIAL_IRQ_INPUT_ONE_IN(s1), .SERIAL_IRQ_INPUT_TWO_IN(s2),
    .SERIAL_IRQ_INPUT_THREE_IN(s3), .ALT_RATE_SEL_IN(ar_sel), .ALT_RATE_VAL_IN(ar_val),
    .SHARED_TWELVE_AS_LINE_IN(tw_line), .LINE_OUT(lout), .LINE_OE_OUT(loe),
    .SET_READY_IN_TWO_OUT(sr2), .INFRARED_RECEIVE_TWO_OUT(ir),
    .SET_READY_CHANGE_FLAG_OUT(flag), .SERIAL_REQ_OUT(req));
  host_irq_model u_host_irq_model (.clk(clk), .svc_en(svc_en), .svc_delay(svc_dly),
    .line_out(lout), .line_oe(loe), .line_pin(lpin), .serial_done(sdone),
    .floppy_done(fdone));
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watcher: each note is compared against the outputs as they stand now
  always @(obs_ev) begin
    while (exp_q.size() > 0) begin
      {m, e} = exp_q.pop_front();
      check(mon & m, e & m);
    end
  end
  task automatic note(input logic [25:0] mk, input logic [25:0] ex);
    exp_q.push_back({mk, ex});
    ->obs_ev;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for the masked outputs to drop, then let the host rest
  task automatic wait_clear(input logic [25:0] mk);
    int n;
    svc_dly = 4'($urandom_range(0, 7));
    svc_en = 1;
    for (n = 0; n < 40 && (mon & mk) !== 25'h0; n++) step(1);
    if (n == 40) begin
      err_count++;
      report_and_stop();
    end else begin
      svc_en = 0;
      step(3);
    end
  endtask
  initial begin
    void'($urandom(32'h8a088e4b));
    step(6);
    rst = 0;
    step(1);
    // Legacy lines three, four and six are driven from the first edge
    note(25'h1efffff, 25'h2c00);
    // A cause seen while the enable is low must leave no trace
    ce = 0;
    sirq = 2'h1;
    step(2);
    note(25'h1800c03, 25'h2c00);
    sirq = 2'h0;
    ce = 1;
    step(1);
    for (int c = 0; c < 2; c++) begin
      com24 = 2'(c);
      sirq = 2'h1;
      step(1);
      sirq = 2'h0;
      step(3);
      note(25'h800c03, {2'h1, 11'h0, 2'h3, 8'h0, 1'(c == 0), 1'(c)});
      wait_clear(25'h800003);
      note(25'h800003, 25'h0);
    end
    par_en = 1;
    for (int a = 0; a < 2; a++) begin
      ack_n = a[0];
      step(3);
      note(25'h05014, {10'h0, 3'h5, 7'h0, !a[0], 1'b0, !a[0], 2'h0});
    end
    ext = 1;
    for (int v = 0; v < 2; v++) begin
      {cfg5, cfg7} = 2'(1 << v);
      step(2);
      note(25'h05000, 25'h1000 << (2 * v));
    end
    {ext, cfg5, cfg7} = 3'h0;
    par_en = 0;
    step(3);
    note(25'h05000, 25'h0);
    fd_ndma = 1;
    for (int f = 0; f < 2; f++) begin
      fd_done = (f == 0);
      fd_byte = (f == 1);
      step(1);
      {fd_done, fd_byte} = 2'h0;
      step(3);
      note(25'h02008, 25'h02008);
      wait_clear(25'h8);
    end
    for (int en = 0; en < 2; en++) begin
      mien = {en[0], 1'b0};
      srn[1] = ~srn[1];
      step(3);
      note(25'h1400000, {en[0], 1'b0, 1'b1, 22'h0});
      msr = 2'h2;
      step(1);
      msr = 2'h0;
      wait_clear(25'h1400000);
    end
    pnp = 1;
    for (int t = 0; t < 12; t++) begin
      int k;
      logic [2:0] s;
      k = $urandom_range(0, 9);
      s = 3'($urandom_range(SRC_SERIAL_ONE, SRC_SIRQ_THREE));
      {s1, s2, s3} = 3'($urandom);
      ack_n = 1'($urandom);
      od = 10'($urandom);
      sel = 30'(s) << (3 * k);
      step(3);
      // Serial and floppy requests are all serviced by now, so those sources read low
      if (s >= SRC_SIRQ_ONE) begin
        e = 26'({s3, s2, s1} >> (s - SRC_SIRQ_ONE)) & 26'h1;
      end else begin
        e = 26'(s == SRC_PARALLEL && !ack_n);
      end
      note(25'hffc00, od[k] ? (25'(!e[0]) << (10 + k)) : (25'h1 << (10 + k)));
      note(25'h1 << k, od[k] ? 26'h0 : e << k);
    end
    // Line twelve has a low source, so only a released pin reads high
    sel = 30'(SRC_SIRQ_ONE) << (3 * LINE_TWELVE);
    {s1, od} = 11'h0;
    tw_line = 0;
    ar_sel = 1;
    ar_val = 1'($urandom);
    step(3);
    note(26'h2141004, {1'b1, 4'h0, 1'b1, 7'h0, 1'b1, 9'h0, ar_val, 2'h0});
    step(1);
    report_and_stop();
  end
endmodule
